/* File: sar_defs.svh */
// Purpose: shared constants for the alert response ends
// Assumes: 50 MHz ref_clk, standard-mode serial bus clock
// Notes: the shared numbers of the block live here; sar_chk keeps its own literals
`ifndef SAR_DEFS_SVH
`define SAR_DEFS_SVH

// ==========================================================
// addresses
`define SAR_ARA 7'h0c
`define SAR_RD_BIT 1'b1
`define SAR_DEV_ADDR_DEF 7'h48

// ==========================================================
// timing
`define SAR_CLK_PERIOD_NS 20
`define SAR_SCL_PERIOD_NS 10000
`define SAR_QTR_CYC ((`SAR_SCL_PERIOD_NS / 4) / `SAR_CLK_PERIOD_NS)
`define SAR_BITS_PER_BYTE 4'h8
`define SAR_LAST_BIT 4'h7

`endif

/* File: sar_pkg.sv */
// Purpose: types for the alert response ends
// Assumes: one-hot state codes
// Notes: all state of the host end is one packed struct; the device end has one plus the previous level in each of its two edge finders
package sar_pkg;

	// ==========================================================
	// device end
	typedef enum logic [5:0] {
		SAR_D_IDLE = 6'h01,
		SAR_D_ADDR = 6'h02,
		SAR_D_AACK = 6'h04,
		SAR_D_DATA = 6'h08,
		SAR_D_DACK = 6'h10,
		SAR_D_WAIT = 6'h20
	} sar_dev_st_t;

	typedef struct packed {
		sar_dev_st_t st;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic sda_oe;
		logic alert_on;
		logic responded;
		logic read_seen;
		logic alert_oe;
		logic answered;
		logic lost;
	} sar_dev_state_t;

	// ==========================================================
	// host end
	typedef enum logic [6:0] {
		SAR_H_IDLE = 7'h01,
		SAR_H_START = 7'h02,
		SAR_H_ADDR = 7'h04,
		SAR_H_AACK = 7'h08,
		SAR_H_DATA = 7'h10,
		SAR_H_NACK = 7'h20,
		SAR_H_STOP = 7'h40
	} sar_host_st_t;

	typedef struct packed {
		sar_host_st_t st;
		logic [15:0] div;
		logic [1:0] q;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic scl_oe;
		logic sda_oe;
		logic [6:0] addr;
		logic addr_valid;
		logic no_ack;
		logic miss;
	} sar_host_state_t;

endpackage

/* File: sar_if.sv */
// Purpose: wired-AND serial bus and shared alert line
// Assumes: every party only pulls low; pull-ups modelled here
// Notes: ext enables stand for further devices on the same wires
`timescale 1ns/10ps
interface sar_if (
	input logic sda_ext_oe,
	input logic alert_ext_oe
);
	logic scl_host_oe;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic alert_dev_oe;
	logic scl;
	logic sda;
	logic alert_n;

	// ==========================================================
	// resolved line levels, low while any party pulls
	assign scl = ~scl_host_oe;
	assign sda = ~(sda_host_oe | sda_dev_oe | sda_ext_oe);
	assign alert_n = ~(alert_dev_oe | alert_ext_oe);

	modport dev (
		input scl,
		input sda,
		input alert_n,
		output sda_dev_oe,
		output alert_dev_oe
	);

	modport host (
		input scl,
		input sda,
		input alert_n,
		output scl_host_oe,
		output sda_host_oe
	);
endinterface

/* File: sar_line_edge.sv */
// Purpose: edge finder for one serial line
// Assumes: line already synchronous to ref_clk
// Notes: idle level of the line is a parameter
`timescale 1ns/10ps
module sar_line_edge #(
	parameter logic IDLE_LEVEL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic line,
	output logic rise,
	output logic fall
);
	logic prev_q;
	logic prev_d;

	// ==========================================================
	// previous level and edges
	always_comb begin
		prev_d = line;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_q <= IDLE_LEVEL;
		end else begin
			prev_q <= prev_d;
		end
	end

	assign rise = line & ~prev_q;
	assign fall = ~line & prev_q;
endmodule

/* File: sar_dev.sv */
// Purpose: device end of the alert response on the serial bus
// Assumes: bus lines synchronous to ref_clk; full register access elsewhere
// Notes: answers only the alert response read; config bits are plain inputs
`timescale 1ns/10ps
`include "sar_defs.svh"

// Contract
// - alert pin acts as bus alert signal
// - alert pin only pulls low or releases
// - host sets active low for shared line
// - host reads alert response address on low
// - nobody owns the alert response address
// - asserting device acks, returns address; others silent
// - returned byte: address high, lsb one
// - lowest address wins the returned byte
// - release needs cause cleared and status read
// - host repeats poll while line low
// - polarity bit chooses level, default active low
// - disable bit set turns output off
// - out-of-limit measurement asserts the alert
module sar_dev #(
	parameter logic [6:0] DEV_ADDR = `SAR_DEV_ADDR_DEF
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	sar_if.dev bus,
	input wire logic smbus_mode,
	input wire logic alert_polarity_sel,
	input wire logic alert_output_disable,
	input wire logic int_temp_oor,
	input wire logic ext_temp_oor,
	input wire logic vdd_oor,
	input wire logic status_read,
	output logic alert_asserted,
	output logic ara_answered,
	output logic ara_lost
);
	import sar_pkg::*;

	sar_dev_state_t s_q;
	sar_dev_state_t s_d;
	logic scl_rise;
	logic scl_fall;
	logic sda_rise;
	logic sda_fall;
	logic start_seen;
	logic stop_seen;
	logic fault_any;
	logic ara_match;
	logic [7:0] reply_byte;

	// ==========================================================
	// line edges
	sar_line_edge #(
		.IDLE_LEVEL(1'b1)
	) u_scl_edge (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.line(bus.scl),
		.rise(scl_rise),
		.fall(scl_fall)
	);

	sar_line_edge #(
		.IDLE_LEVEL(1'b1)
	) u_sda_edge (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.line(bus.sda),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// ==========================================================
	// bus conditions and decode
	// start and stop are data edges while the clock stands high
	assign start_seen = bus.scl & sda_fall;
	assign stop_seen = bus.scl & sda_rise;
	// any channel outside its limits
	assign fault_any = int_temp_oor | ext_temp_oor | vdd_oor;
	// the reserved address is matched, never used as own address
	assign ara_match = (s_q.shift == {`SAR_ARA, `SAR_RD_BIT});
	// own address in the upper bits, lsb forced high
	assign reply_byte = {DEV_ADDR, 1'b1};

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.answered = 1'b0;
		s_d.lost = 1'b0;

		// a status read is remembered while the alert stands
		if (status_read && s_q.alert_on) begin
			s_d.read_seen = 1'b1;
		end

		// alert set wins over any release in the same cycle
		if (fault_any) begin
			if (!s_q.alert_on) begin
				s_d.read_seen = 1'b0;
				s_d.responded = 1'b0;
			end
			s_d.alert_on = 1'b1;
		end else if (s_q.alert_on && (s_q.read_seen || status_read)
				&& (s_q.responded || !smbus_mode)) begin
			// release once cleared and read, and with smbus_mode set only once answered
			s_d.alert_on = 1'b0;
			s_d.read_seen = 1'b0;
			s_d.responded = 1'b0;
		end

		// bus sequencing; stop and start override any state
		if (stop_seen) begin
			s_d.st = SAR_D_IDLE;
			s_d.sda_oe = 1'b0;
		end else if (start_seen) begin
			s_d.st = SAR_D_ADDR;
			s_d.cnt = 4'h0;
			s_d.sda_oe = 1'b0;
		end else begin
			case (s_q.st)
				SAR_D_IDLE: begin
					s_d.sda_oe = 1'b0;
				end
				SAR_D_ADDR: begin
					// address bits are taken on the clock rise
					if (scl_rise) begin
						s_d.shift = {s_q.shift[6:0], bus.sda};
						s_d.cnt = 4'(s_q.cnt + 4'h1);
					end else if (scl_fall && s_q.cnt == `SAR_BITS_PER_BYTE) begin
						if (ara_match && s_q.alert_on && smbus_mode) begin
							// acknowledge only while asserting
							s_d.sda_oe = 1'b1;
							s_d.st = SAR_D_AACK;
						end else begin
							// not ours: stay silent until the next start
							s_d.st = SAR_D_WAIT;
						end
					end
				end
				SAR_D_AACK: begin
					// end of ack bit: present first reply bit
					if (scl_fall) begin
						s_d.shift = reply_byte;
						s_d.sda_oe = ~reply_byte[7];
						s_d.cnt = 4'h0;
						s_d.st = SAR_D_DATA;
					end
				end
				SAR_D_DATA: begin
					if (scl_rise) begin
						if (!s_q.sda_oe && !bus.sda) begin
							// a lower address pulled a released bit low
							s_d.sda_oe = 1'b0;
							s_d.lost = 1'b1;
							s_d.st = SAR_D_WAIT; // alert stays on
						end else begin
							s_d.cnt = 4'(s_q.cnt + 4'h1);
						end
					end else if (scl_fall) begin
						if (s_q.cnt == `SAR_BITS_PER_BYTE) begin
							// whole byte sent unopposed: this device won
							s_d.sda_oe = 1'b0;
							s_d.responded = s_q.alert_on;
							s_d.answered = 1'b1;
							s_d.st = SAR_D_DACK;
						end else begin
							s_d.shift = {s_q.shift[6:0], 1'b0};
							s_d.sda_oe = ~s_q.shift[6];
						end
					end
				end
				SAR_D_DACK: begin
					// host acks or nacks; nothing more to send
					if (scl_fall) begin
						s_d.st = SAR_D_WAIT;
					end
				end
				SAR_D_WAIT: begin
					s_d.sda_oe = 1'b0;
				end
				default: begin
					s_d.st = SAR_D_IDLE;
					s_d.sda_oe = 1'b0;
				end
			endcase
		end

		// pin pulls low whenever the chosen polarity calls for a low level;
		// disabled means never pulled, so the line floats high
		if (alert_output_disable) begin
			s_d.alert_oe = 1'b0;
		end else if (alert_polarity_sel) begin
			s_d.alert_oe = ~s_d.alert_on; // active high
		end else begin
			s_d.alert_oe = s_d.alert_on; // active low, reset default
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q.st <= SAR_D_IDLE;
			s_q.cnt <= 4'h0;
			s_q.shift <= 8'h00;
			s_q.sda_oe <= 1'b0;
			s_q.alert_on <= 1'b0;
			s_q.responded <= 1'b0;
			s_q.read_seen <= 1'b0;
			s_q.alert_oe <= 1'b0;
			s_q.answered <= 1'b0;
			s_q.lost <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs, all straight from the state register
	// open drain: only an enable leaves the block, level always low
	assign bus.sda_dev_oe = s_q.sda_oe;
	assign bus.alert_dev_oe = s_q.alert_oe;
	assign alert_asserted = s_q.alert_on;
	assign ara_answered = s_q.answered;
	assign ara_lost = s_q.lost;
endmodule

/* File: sar_host.sv */
// Purpose: host end polling the alert response address
// Assumes: single host, fixed standard-mode bit rate
// Notes: each bit is four quarter slots from a divider enable
`timescale 1ns/10ps
`include "sar_defs.svh"
module sar_host #(
	parameter int QTR_CYC = `SAR_QTR_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	sar_if.host bus,
	input wire logic poll_en,
	output logic [6:0] alert_addr,
	output logic alert_addr_valid,
	output logic poll_no_ack,
	output logic poll_busy
);
	import sar_pkg::*;

	sar_host_state_t s_q;
	sar_host_state_t s_d;
	logic tick;

	// ==========================================================
	// quarter-bit enable
	assign tick = (s_q.div == 16'(QTR_CYC - 1));

	// ==========================================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.addr_valid = 1'b0;
		s_d.div = tick ? 16'h0000 : 16'(s_q.div + 16'h0001);
		if (tick) begin
			s_d.q = 2'(s_q.q + 2'h1);
			case (s_q.st)
				SAR_H_IDLE: begin
					s_d.scl_oe = 1'b0;
					s_d.sda_oe = 1'b0;
					s_d.q = 2'h0;
					// poll again for as long as the line stays low
					if (poll_en && !bus.alert_n) begin
						s_d.st = SAR_H_START;
						s_d.no_ack = 1'b0;
					end
				end
				SAR_H_START: begin
					if (s_q.q == 2'h0) begin
						s_d.sda_oe = 1'b1;
					end else if (s_q.q == 2'h2) begin
						s_d.scl_oe = 1'b1;
					end else if (s_q.q == 2'h3) begin
						s_d.shift = {`SAR_ARA, `SAR_RD_BIT};
						s_d.cnt = 4'h0;
						s_d.st = SAR_H_ADDR;
					end
				end
				SAR_H_ADDR, SAR_H_AACK, SAR_H_DATA, SAR_H_NACK: begin
					case (s_q.q)
						2'h0: begin
							// set data while clock is low
							s_d.sda_oe = (s_q.st == SAR_H_ADDR) ? ~s_q.shift[7] : 1'b0;
						end
						2'h1: begin
							s_d.scl_oe = 1'b0;
						end
						2'h2: begin
							if (s_q.st == SAR_H_AACK) begin
								s_d.miss = bus.sda;
							end else if (s_q.st == SAR_H_DATA) begin
								s_d.shift = {s_q.shift[6:0], bus.sda};
							end
						end
						2'h3: begin
							s_d.scl_oe = 1'b1;
							s_d.cnt = 4'(s_q.cnt + 4'h1);
							if (s_q.st == SAR_H_ADDR) begin
								s_d.shift = {s_q.shift[6:0], 1'b0};
								if (s_q.cnt == `SAR_LAST_BIT) begin
									s_d.st = SAR_H_AACK;
								end
							end else if (s_q.st == SAR_H_AACK) begin
								s_d.cnt = 4'h0;
								s_d.no_ack = s_q.miss;
								s_d.st = s_q.miss ? SAR_H_STOP : SAR_H_DATA;
							end else if (s_q.st == SAR_H_DATA) begin
								if (s_q.cnt == `SAR_LAST_BIT) begin
									s_d.st = SAR_H_NACK;
								end
							end else begin
								// byte done: upper seven bits name the device
								s_d.addr = s_q.shift[7:1];
								s_d.addr_valid = 1'b1;
								s_d.st = SAR_H_STOP;
							end
						end
						default: begin
							s_d.scl_oe = 1'b1;
						end
					endcase
				end
				SAR_H_STOP: begin
					if (s_q.q == 2'h0) begin
						s_d.sda_oe = 1'b1;
					end else if (s_q.q == 2'h1) begin
						s_d.scl_oe = 1'b0;
					end else if (s_q.q == 2'h2) begin
						s_d.sda_oe = 1'b0;
					end else begin
						s_d.st = SAR_H_IDLE;
					end
				end
				default: begin
					s_d.st = SAR_H_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q.st <= SAR_H_IDLE;
			s_q.div <= 16'h0000;
			s_q.q <= 2'h0;
			s_q.cnt <= 4'h0;
			s_q.shift <= 8'h00;
			s_q.scl_oe <= 1'b0;
			s_q.sda_oe <= 1'b0;
			s_q.addr <= 7'h00;
			s_q.addr_valid <= 1'b0;
			s_q.no_ack <= 1'b0;
			s_q.miss <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// outputs from the state register
	assign bus.scl_host_oe = s_q.scl_oe;
	assign bus.sda_host_oe = s_q.sda_oe;
	assign alert_addr = s_q.addr;
	assign alert_addr_valid = s_q.addr_valid;
	assign poll_no_ack = s_q.no_ack;
	assign poll_busy = (s_q.st != SAR_H_IDLE);
endmodule

/* File: sar_chk_sva.sv */
// Purpose: bus checks for the alert response ends
// Assumes: lines synchronous to ref_clk
// Notes: bit count restarts at each start condition
`timescale 1ns/10ps
module sar_chk #(
	parameter logic [6:0] DEV_ADDR = 7'h48
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic sda_dev_oe,
	input wire logic alert_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q;
	logic sda_q;
	logic rise;
	logic exp_bit;
	logic data_ph;
	logic [4:0] bit_q;
	logic [7:0] addr_q;
	logic [7:0] exp_byte;

	// ==========================================================
	// helper: expected reply bit for the current rise
	assign exp_byte = {DEV_ADDR, 1'b1};
	assign rise = scl & ~scl_q;
	assign exp_bit = exp_byte[3'(5'd16 - bit_q)];
	assign data_ph = (bit_q > 5'h08) && (bit_q < 5'h11);

	// line history, bit count and address byte
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_q <= 5'h1f;
			addr_q <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl & scl_q & sda_q & ~sda) begin
				bit_q <= 5'h00;
			end else if (rise && bit_q != 5'h1f) begin
				bit_q <= bit_q + 5'h01;
			end
			if (rise && bit_q < 5'h08) begin
				addr_q <= {addr_q[6:0], sda};
			end
		end
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_host_ara;
		rise && bit_q == 5'h07 |-> {addr_q[6:0], sda} == 8'h19;
	endproperty
	a_host_ara: assert property (p_host_ara)
		else $error("poll address wrong");

	property p_dev_ack;
		rise && bit_q == 5'h08 && addr_q == 8'h19 && alert_dev_oe |-> sda_dev_oe && !sda;
	endproperty
	a_dev_ack: assert property (p_dev_ack)
		else $error("alerting device gave no ack");

	property p_dev_silent;
		rise && bit_q == 5'h08 && !alert_dev_oe |-> !sda_dev_oe;
	endproperty
	a_dev_silent: assert property (p_dev_silent)
		else $error("quiet device acked");

	property p_chg_scl_low;
		$changed(sda_dev_oe) |-> !scl;
	endproperty
	a_chg_scl_low: assert property (p_chg_scl_low)
		else $error("device moved sda with scl high");

	property p_lsb_one;
		rise && bit_q == 5'h10 |-> !sda_dev_oe;
	endproperty
	a_lsb_one: assert property (p_lsb_one)
		else $error("reply lsb not one");

	property p_data_bits;
		rise && data_ph && sda_dev_oe |-> !exp_bit;
	endproperty
	a_data_bits: assert property (p_data_bits)
		else $error("reply bit differs from address");

	property p_lost_quiet;
		rise && data_ph && exp_bit && !sda |=> !sda_dev_oe [*8] ##1 !sda_dev_oe [*8];
	endproperty
	a_lost_quiet: assert property (p_lost_quiet)
		else $error("device kept sending after loss");

	property p_alert_hold;
		rise && data_ph && exp_bit && !sda && alert_dev_oe |=> alert_dev_oe [*8];
	endproperty
	a_alert_hold: assert property (p_alert_hold)
		else $error("alert dropped after loss");

	// main scenarios reached
	c_ack: cover property (rise && bit_q == 5'h08 && sda_dev_oe);
	c_lost: cover property (rise && data_ph && exp_bit && !sda);
	c_lsb: cover property (rise && bit_q == 5'h10 && sda);
endmodule

/* File: smbus_alert_response_tb_top.sv */
// Purpose: self-checking bench for host and device ends
// Assumes: short bit slots, extra devices via ext enables
// Notes: outputs sampled on falling edge, inputs driven on rising
`timescale 1ns/10ps
`include "sar_defs.svh"
module smbus_alert_response_tb_top;
	localparam logic [6:0] DEV_ADDR = 7'h53;
	logic ref_clk = 1'b0;
	logic sys_rst, sda_ext_oe, alert_ext_oe, smbus_mode, alert_polarity_sel;
	logic alert_output_disable, status_read, poll_en;
	logic alert_addr_valid, poll_no_ack, poll_busy, alert_asserted, ara_answered, ara_lost;
	logic [2:0] oor;
	logic [6:0] alert_addr;
	int err_total = 0;
	int samples_checked = 0;
	int lost_total = 0;
	int answered_total = 0;

	// ==========================================================
	// clock, ends and checker
	always #10 ref_clk = ~ref_clk;
	sar_if sar_if_i (.sda_ext_oe(sda_ext_oe), .alert_ext_oe(alert_ext_oe));
	sar_dev #(.DEV_ADDR(DEV_ADDR)) sar_dev_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.bus(sar_if_i), .smbus_mode(smbus_mode), .alert_polarity_sel(alert_polarity_sel),
		.alert_output_disable(alert_output_disable), .int_temp_oor(oor[0]),
		.ext_temp_oor(oor[1]), .vdd_oor(oor[2]), .status_read(status_read),
		.alert_asserted(alert_asserted), .ara_answered(ara_answered), .ara_lost(ara_lost));
	sar_host #(.QTR_CYC(4)) sar_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus(sar_if_i),
		.poll_en(poll_en), .alert_addr(alert_addr), .alert_addr_valid(alert_addr_valid),
		.poll_no_ack(poll_no_ack), .poll_busy(poll_busy));
	sar_chk #(.DEV_ADDR(DEV_ADDR)) sar_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.sda_dev_oe(sar_if_i.sda_dev_oe), .alert_dev_oe(sar_if_i.alert_dev_oe),
		.scl(sar_if_i.scl), .sda(sar_if_i.sda));

	// counts arbitration losses and replies sent unopposed
	always @(posedge ref_clk) begin
		if (ara_lost === 1'b1) lost_total++;
		if (ara_answered === 1'b1) answered_total++;
	end

	// ==========================================================
	// tasks
	task complete_run;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chk_addr(input logic [6:0] got, input logic [6:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// lower address wins the returned byte
	function automatic logic [6:0] exp_winner(input logic [6:0] a, input logic [6:0] b);
		return (a < b) ? a : b;
	endfunction

	// shared alert level for one device: disabled floats high, else per polarity
	function automatic logic exp_alert_n(input logic on, input logic pol, input logic dis);
		return dis | (pol ? on : ~on);
	endfunction

	task settle(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask

	task set_oor(input logic [2:0] v);
		@(posedge ref_clk);
		oor <= v;
	endtask

	task pulse_status;
		@(posedge ref_clk);
		status_read <= 1'b1;
		@(posedge ref_clk);
		status_read <= 1'b0;
	endtask

	// bounded wait on one completion condition
	task wait_on(input int sel);
		int k;
		logic hit;
		hit = 1'b0;
		for (k = 0; k < 3000 && !hit; k++) begin
			@(negedge ref_clk);
			case (sel)
				0: hit = (alert_addr_valid === 1'b1);
				1: hit = (sar_if_i.sda_dev_oe === 1'b1);
				2: hit = (lost_total > 0);
				3: hit = (poll_busy === 1'b0);
				default: hit = (poll_no_ack === 1'b1);
			endcase
		end
		if (!hit) begin
			err_total++;
			$display("Error t=%0t got %h exp %h", $time, 1'b0, 1'b1);
			complete_run();
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		int ch;
		sys_rst = 1'b1;
		{sda_ext_oe, alert_ext_oe, alert_polarity_sel, alert_output_disable} = 4'h0;
		{status_read, poll_en, oor} = 5'h00;
		smbus_mode = 1'b1;
		void'($urandom(94502));
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		settle(2);
		chk_bit(alert_asserted, 1'b0);
		chk_bit(sar_if_i.alert_n, 1'b1);
		$display("test reset done");
		// each channel: clear and read before poll, release after answer
		for (ch = 0; ch < 3; ch++) begin
			set_oor((3'b001 << ch) | 3'($urandom_range(7, 0)));
			settle(2);
			chk_bit(sar_if_i.alert_n, 1'b0);
			repeat ($urandom_range(20, 3)) @(posedge ref_clk);
			set_oor(3'b000);
			pulse_status();
			settle(3);
			chk_bit(alert_asserted, 1'b1);
			@(posedge ref_clk);
			poll_en <= 1'b1;
			wait_on(0);
			chk_addr(alert_addr, DEV_ADDR);
			chk_addr(7'(answered_total), 7'(ch + 1));
			settle(3);
			chk_bit(sar_if_i.alert_n, 1'b1);
			@(posedge ref_clk);
			poll_en <= 1'b0;
			wait_on(3);
			$display("test channel %0d done", ch);
		end
		// lower address device pulls sda over the ack and the first reply bit
		set_oor(3'b100);
		@(posedge ref_clk);
		poll_en <= 1'b1;
		wait_on(1);
		@(posedge ref_clk);
		sda_ext_oe <= 1'b1;
		wait_on(2);
		chk_bit(alert_asserted, 1'b1);
		// hold the pull past the host's sample of that bit, let go while scl is low
		repeat (8) @(posedge ref_clk);
		sda_ext_oe <= 1'b0;
		wait_on(0);
		chk_addr(alert_addr, exp_winner(7'h3f, DEV_ADDR));
		wait_on(0);
		chk_addr(alert_addr, DEV_ADDR);
		chk_addr(7'(lost_total), 7'h01);
		chk_addr(7'(answered_total), 7'h04);
		@(posedge ref_clk);
		poll_en <= 1'b0;
		wait_on(3);
		set_oor(3'b000);
		pulse_status();
		settle(3);
		chk_bit(sar_if_i.alert_n, 1'b1);
		$display("test arbitration done");
		// another device alerts, nobody answers
		@(posedge ref_clk);
		alert_ext_oe <= 1'b1;
		poll_en <= 1'b1;
		wait_on(4);
		chk_bit(sar_if_i.sda_dev_oe, 1'b0);
		@(posedge ref_clk);
		alert_ext_oe <= 1'b0;
		poll_en <= 1'b0;
		wait_on(3);
		$display("test no ack done");
		// disable, active high, release without poll off the two-wire mode
		@(posedge ref_clk);
		alert_output_disable <= 1'b1;
		smbus_mode <= 1'b0;
		set_oor(3'b010);
		settle(2);
		chk_bit(alert_asserted, 1'b1);
		chk_bit(sar_if_i.alert_n, exp_alert_n(1'b1, 1'b0, 1'b1));
		@(posedge ref_clk);
		alert_output_disable <= 1'b0;
		alert_polarity_sel <= 1'b1;
		settle(2);
		chk_bit(sar_if_i.alert_n, exp_alert_n(1'b1, 1'b1, 1'b0));
		set_oor(3'b000);
		pulse_status();
		settle(3);
		chk_bit(alert_asserted, 1'b0);
		chk_bit(sar_if_i.alert_n, exp_alert_n(1'b0, 1'b1, 1'b0));
		@(posedge ref_clk);
		alert_polarity_sel <= 1'b0; // shared line needs active low
		smbus_mode <= 1'b1;
		settle(2);
		chk_bit(sar_if_i.alert_n, exp_alert_n(1'b0, 1'b0, 1'b0));
		$display("test modes done");
		complete_run();
	end
endmodule
